// >>> hw/bcfg_pkg.sv
// Package for the bridge type-1 configuration header register bank.
// Assumes a 32-bit AXI4-Lite register bus; offsets are byte addresses.
package bcfg_pkg;

	localparam logic [7:0] BCFG_OFF_CLASS = 8'h08;
	localparam logic [7:0] BCFG_OFF_HDR = 8'h0C;
	localparam logic [7:0] BCFG_OFF_RSV0 = 8'h10;
	localparam logic [7:0] BCFG_OFF_RSV1 = 8'h14;
	localparam logic [7:0] BCFG_OFF_BUS = 8'h18;
	localparam logic [7:0] BCFG_OFF_IO = 8'h1C;
	localparam logic [7:0] BCFG_OFF_MODE = 8'h40;

	localparam logic [7:0] BCFG_PROG_IF = 8'h00;
	localparam logic [7:0] BCFG_SUB_CLASS = 8'h04;
	localparam logic [7:0] BCFG_BASE_CLASS = 8'h06;
	localparam logic [6:0] BCFG_HDR_LAYOUT = 7'h01;
	localparam logic BCFG_HDR_MULTI = 1'b0;
	localparam logic [7:0] BCFG_HDR_TOP = 8'h00;

	localparam logic [3:0] BCFG_CLS_RST = 4'h0;
	localparam int BCFG_CLS_LSB = 2;
	localparam logic [7:0] BCFG_LAT_PCI_RST = 8'h00;
	localparam logic [7:0] BCFG_LAT_PCIX_RST = 8'h40;
	localparam logic [7:0] BCFG_BUS_RST = 8'h00;
	localparam logic [1:0] BCFG_IO_CAP = 2'h1;
	localparam logic [1:0] BCFG_IO_RSV = 2'h0;
	localparam logic [3:0] BCFG_IO_RST = 4'h0;
	localparam int BCFG_IO_FLD_LSB = 4;

	localparam logic [1:0] BCFG_RESP_OKAY = 2'h0;
	localparam logic [1:0] BCFG_RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic reverse;
		logic pcix;
	} bcfg_mode_s;

	typedef struct packed {
		logic [3:0] cls;
		logic [7:0] pri_lat;
		logic [7:0] sec_lat;
		logic [7:0] pri_bus;
		logic [7:0] sec_bus;
		logic [7:0] sub_bus;
		logic [3:0] io_base;
		logic [3:0] io_limit;
	} bcfg_regs_s;

	typedef struct packed {
		logic [3:0] cls;
		logic [7:0] pri_bus;
		logic [7:0] sec_bus;
		logic [7:0] sub_bus;
		logic [3:0] io_base;
		logic [3:0] io_limit;
	} bcfg_view_s;

endpackage : bcfg_pkg

// >>> hw/bcfg_regfile.sv
// Configuration header fields: reset, write merge and read mux.
// Assumes the bus slave hands it one decoded write and one read address.
`timescale 1ns/1ps
`default_nettype none
module bcfg_regfile
	import bcfg_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire bcfg_mode_s mode,
	input wire logic wr_en,
	input wire logic [7:0] wr_addr,
	input wire logic [31:0] wr_data,
	input wire logic [3:0] wr_strb,
	input wire logic [7:0] rd_addr,
	output logic [31:0] rd_data,
	output logic rd_hit,
	output logic wr_hit,
	output bcfg_regs_s regs
);

	bcfg_regs_s next_regs;

	function automatic logic [7:0] merge8(input logic [7:0] old,
		input logic [7:0] nw, input logic en);
		merge8 = en ? nw : old;
	endfunction : merge8

	function automatic logic known(input logic [7:0] a);
		known = (a == BCFG_OFF_CLASS) || (a == BCFG_OFF_HDR) ||
			(a == BCFG_OFF_RSV0) || (a == BCFG_OFF_RSV1) ||
			(a == BCFG_OFF_BUS) || (a == BCFG_OFF_IO);
	endfunction : known

	logic [7:0] lat_rst;
	assign lat_rst = mode.pcix ? BCFG_LAT_PCIX_RST : BCFG_LAT_PCI_RST;
	assign rd_hit = known(rd_addr);
	assign wr_hit = known(wr_addr);

	always_comb
	begin
		next_regs = regs;
		if (wr_en && wr_addr == BCFG_OFF_HDR)
		begin
			if (wr_strb[0])
				next_regs.cls = wr_data[BCFG_CLS_LSB +: 4];
			if (wr_strb[1] && mode.reverse)
				next_regs.pri_lat = wr_data[15:8];
		end
		if (wr_en && wr_addr == BCFG_OFF_BUS)
		begin
			next_regs.pri_bus = merge8(regs.pri_bus, wr_data[7:0],
				wr_strb[0]);
			next_regs.sec_bus = merge8(regs.sec_bus, wr_data[15:8],
				wr_strb[1]);
			next_regs.sub_bus = merge8(regs.sub_bus, wr_data[23:16],
				wr_strb[2]);
			if (wr_strb[3] && !mode.reverse)
				next_regs.sec_lat = wr_data[31:24];
		end
		if (wr_en && wr_addr == BCFG_OFF_IO)
		begin
			if (wr_strb[0])
				next_regs.io_base = wr_data[BCFG_IO_FLD_LSB +: 4];
			if (wr_strb[1])
				next_regs.io_limit = wr_data[12 +: 4];
		end
	end

	// Latency resets follow the mode straps seen during reset
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			regs.cls <= BCFG_CLS_RST;
			regs.pri_lat <= mode.reverse ? lat_rst : BCFG_LAT_PCI_RST;
			regs.sec_lat <= mode.reverse ? BCFG_LAT_PCI_RST : lat_rst;
			regs.pri_bus <= BCFG_BUS_RST;
			regs.sec_bus <= BCFG_BUS_RST;
			regs.sub_bus <= BCFG_BUS_RST;
			regs.io_base <= BCFG_IO_RST;
			regs.io_limit <= BCFG_IO_RST;
		end
		else
			regs <= next_regs;
	end

	always_comb
	begin
		rd_data = 32'h00000000;
		case (rd_addr)
			BCFG_OFF_CLASS: rd_data = {BCFG_BASE_CLASS, BCFG_SUB_CLASS,
				BCFG_PROG_IF, 8'h00};
			BCFG_OFF_HDR: rd_data = {BCFG_HDR_TOP, BCFG_HDR_MULTI,
				BCFG_HDR_LAYOUT, regs.pri_lat, 2'b00, regs.cls,
				2'b00};
			BCFG_OFF_BUS: rd_data = {regs.sec_lat, regs.sub_bus,
				regs.sec_bus, regs.pri_bus};
			BCFG_OFF_IO: rd_data = {16'h0000, regs.io_limit, BCFG_IO_RSV,
				BCFG_IO_CAP, regs.io_base, BCFG_IO_RSV, BCFG_IO_CAP};
			default: rd_data = 32'h00000000;
		endcase
	end

endmodule : bcfg_regfile
`default_nettype wire

// >>> hw/bcfg_top.sv
// Operation
// - Class code read-only bridge-to-bridge values.
// - Cache line bits 2..5 writable, reset zero.
// - Cache line bits 1:0, 7:6 read zero.
// - Primary latency RO forward, RW reverse.
// - Secondary latency RW forward, RO reverse.
// - Header type read-only, layout one, single.
// - Header top byte reads zero.
// - Dwords 10h to 17h reserved.
// - Three writable bus numbers reset zero.
// - I/O bytes advertise 32-bit, reserved zero.
// - I/O base nibble writable, reset zero.
// - I/O limit nibble writable, reset zero.
//
// Top of the bridge configuration header bank: AXI4-Lite slave.
// Assumes mode straps are stable while aresetn is high.
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module bcfg_top
	import bcfg_pkg::*;
#(
	parameter int ADDR_W = 8
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic mode_reverse,
	input wire logic mode_pcix,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [7:0] cfg_pri_bus,
	output logic [7:0] cfg_sec_bus,
	output logic [7:0] cfg_sub_bus,
	output logic [3:0] cfg_io_base,
	output logic [3:0] cfg_io_limit,
	output logic [3:0] cfg_cache_line
);

	////////////////////////////////////////////////////////////////////////
	// Bus state

	typedef struct packed {
		logic aw_full;
		logic [7:0] aw_addr;
		logic w_full;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic b_valid;
		logic [1:0] b_resp;
		logic r_valid;
		logic [1:0] r_resp;
		logic [31:0] r_data;
		logic [1:0] mode_rd;
	} bcfg_bus_s;

	bcfg_bus_s st;
	bcfg_bus_s next_st;
	bcfg_mode_s mode;
	bcfg_regs_s regs;
	logic [31:0] rf_rdata;
	logic rf_rd_hit;
	logic rf_wr_hit;
	logic do_write;
	logic [7:0] ar_addr8;

	assign mode.reverse = mode_reverse;
	assign mode.pcix = mode_pcix;
	assign ar_addr8 = {s_axi_araddr[7:2], 2'b00};

	// Write fires once both halves are held and no response is pending
	assign do_write = st.aw_full && st.w_full && !st.b_valid;

	assign s_axi_awready = !st.aw_full && !st.b_valid;
	assign s_axi_wready = !st.w_full && !st.b_valid;
	assign s_axi_arready = !st.r_valid;
	assign s_axi_bvalid = st.b_valid;
	assign s_axi_bresp = st.b_resp;
	assign s_axi_rvalid = st.r_valid;
	assign s_axi_rresp = st.r_resp;
	assign s_axi_rdata = st.r_data;

	////////////////////////////////////////////////////////////////////////
	// Register file

	bcfg_regfile u_regfile (
		.aclk(aclk),
		.aresetn(aresetn),
		.mode(mode),
		.wr_en(do_write && rf_wr_hit),
		.wr_addr(st.aw_addr),
		.wr_data(st.w_data),
		.wr_strb(st.w_strb),
		.rd_addr(ar_addr8),
		.rd_data(rf_rdata),
		.rd_hit(rf_rd_hit),
		.wr_hit(rf_wr_hit),
		.regs(regs)
	);

	////////////////////////////////////////////////////////////////////////
	// Handshake logic

	always_comb
	begin
		next_st = st;
		next_st.mode_rd = {mode.reverse, mode.pcix};
		if (s_axi_awvalid && s_axi_awready)
		begin
			next_st.aw_full = 1'b1;
			next_st.aw_addr = {s_axi_awaddr[7:2], 2'b00};
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			next_st.w_full = 1'b1;
			next_st.w_data = s_axi_wdata;
			next_st.w_strb = s_axi_wstrb;
		end
		if (do_write)
		begin
			next_st.aw_full = 1'b0;
			next_st.w_full = 1'b0;
			next_st.b_valid = 1'b1;
			// Mode register is read-only; writes to it just complete OKAY
			if (rf_wr_hit || st.aw_addr == BCFG_OFF_MODE)
				next_st.b_resp = BCFG_RESP_OKAY;
			else
				next_st.b_resp = BCFG_RESP_SLVERR;
		end
		if (st.b_valid && s_axi_bready)
			next_st.b_valid = 1'b0;
		if (s_axi_arvalid && s_axi_arready)
		begin
			next_st.r_valid = 1'b1;
			if (rf_rd_hit)
			begin
				next_st.r_data = rf_rdata;
				next_st.r_resp = BCFG_RESP_OKAY;
			end
			else if (ar_addr8 == BCFG_OFF_MODE)
			begin
				next_st.r_data = {30'h00000000, st.mode_rd};
				next_st.r_resp = BCFG_RESP_OKAY;
			end
			else
			begin
				next_st.r_data = 32'h00000000;
				next_st.r_resp = BCFG_RESP_SLVERR;
			end
		end
		else if (st.r_valid && s_axi_rready)
			next_st.r_valid = 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			st <= '0;
		else
			st <= next_st;
	end

	////////////////////////////////////////////////////////////////////////
	// Field outputs for the forwarding logic

	assign cfg_pri_bus = regs.pri_bus;
	assign cfg_sec_bus = regs.sec_bus;
	assign cfg_sub_bus = regs.sub_bus;
	assign cfg_io_base = regs.io_base;
	assign cfg_io_limit = regs.io_limit;
	assign cfg_cache_line = regs.cls;

endmodule : bcfg_top
`default_nettype wire

// >>> verif/bcfg_checker.sv
// Checker for the bridge configuration bank bus and field outputs.
// Assumes one clock aclk and synchronous reset aresetn.
`timescale 1ns/1ps
`default_nettype none
module bcfg_checker
	import bcfg_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic [7:0] cfg_sec_bus,
	input wire logic [3:0] cfg_cache_line,
	input wire logic [3:0] cfg_io_base,
	input wire logic [3:0] cfg_io_limit
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	////////////////////////////////////////////////////////////////////////
	sequence s_rtake;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence s_wdone;
		$rose(s_axi_bvalid);
	endsequence
	property p_rv; s_rtake |=> s_axi_rvalid; endproperty
	property p_rh; s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata); endproperty
	property p_bh; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
	property p_bz; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	property p_er; s_axi_rvalid && s_axi_rresp == BCFG_RESP_SLVERR |->
		s_axi_rdata == 32'h0; endproperty
	// Fields may only move on the edge that completes a write
	property p_cl; $changed(cfg_cache_line) |-> s_wdone; endproperty
	property p_sb; $changed(cfg_sec_bus) |-> s_wdone; endproperty
	property p_io; $changed(cfg_io_limit) |-> s_wdone; endproperty
	property p_rs; $rose(aresetn) |-> cfg_sec_bus == 8'h00 &&
		cfg_cache_line == 4'h0 && cfg_io_limit == 4'h0 &&
		cfg_io_base == 4'h0; endproperty
	a_rv: assert property (p_rv) else $error("no read answer");
	a_rh: assert property (p_rh) else $error("read answer moved");
	a_bh: assert property (p_bh) else $error("write answer dropped");
	a_bz: assert property (p_bz) else $error("write taken early");
	a_er: assert property (p_er) else $error("error read not zero");
	a_cl: assert property (p_cl) else $error("cache line moved");
	a_sb: assert property (p_sb) else $error("bus number moved");
	a_io: assert property (p_io) else $error("io limit moved");
	a_rs: assert property (p_rs) else $error("bad reset fields");
endmodule : bcfg_checker
`default_nettype wire

// >>> verif/tb.sv
// Self-checking bench for the configuration bank over AXI4-Lite.
// Assumes the straps change only while reset is held low.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
	num_errors++; $display("unexpected %s exp %h got %h", n, e, g); end end
module tb;
	import bcfg_pkg::*;
	logic aclk, aresetn, mode_reverse, mode_pcix;
	logic [7:0] s_axi_awaddr, s_axi_araddr, cfg_pri_bus, cfg_sec_bus;
	logic [7:0] cfg_sub_bus;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb, cfg_io_base, cfg_io_limit, cfg_cache_line;
	logic [2:0] s_axi_awprot, s_axi_arprot;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	int num_errors, num_checks;
	int stall;
	bcfg_top dut (.*);
	////////////////////////////////////////////////////////////////////////
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic [1:0] e);
		logic ta, tw, ka, kw;
		ta = 0;
		tw = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= (stall == 0);
		while (!(ta && tw))
		begin
			@(negedge aclk);
			ka = s_axi_awvalid && s_axi_awready;
			kw = s_axi_wvalid && s_axi_wready;
			@(posedge aclk);
			if (ka) s_axi_awvalid <= 0;
			if (kw) s_axi_wvalid <= 0;
			ta |= ka;
			tw |= kw;
		end
		do @(negedge aclk); while (!s_axi_bvalid);
		// Back-pressure: the answer must stand until bready comes
		if (stall > 0)
		begin
			repeat (stall) @(negedge aclk);
			@(posedge aclk);
			s_axi_bready <= 1;
			@(negedge aclk);
			`CHK("bvalid", 1'b1, s_axi_bvalid)
		end
		`CHK("bresp", e, s_axi_bresp)
		@(posedge aclk);
		s_axi_bready <= 0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= (stall == 0);
		do @(negedge aclk); while (!s_axi_arready);
		@(posedge aclk);
		s_axi_arvalid <= 0;
		do @(negedge aclk); while (!s_axi_rvalid);
		if (stall > 0)
		begin
			repeat (stall) @(negedge aclk);
			@(posedge aclk);
			s_axi_rready <= 1;
			@(negedge aclk);
			`CHK("rvalid", 1'b1, s_axi_rvalid)
		end
		`CHK("rdata", e, s_axi_rdata)
		`CHK("rresp", r, s_axi_rresp)
		@(posedge aclk);
		s_axi_rready <= 0;
	endtask : rd
	task automatic t_mode(input logic r, input logic p);
		logic [7:0] pl, sl;
		pl = (r && p) ? 8'h40 : 8'h00;
		sl = (!r && p) ? 8'h40 : 8'h00;
		@(posedge aclk);
		aresetn <= 0;
		mode_reverse <= r;
		mode_pcix <= p;
		repeat (5) @(posedge aclk);
		aresetn <= 1;
		rd(8'h08, 32'h0604_0000, BCFG_RESP_OKAY);
		rd(8'h0C, {16'h0001, pl, 8'h00}, BCFG_RESP_OKAY);
		rd(8'h18, {sl, 24'h00_0000}, BCFG_RESP_OKAY);
		rd(8'h1C, 32'h0000_0101, BCFG_RESP_OKAY);
		rd(BCFG_OFF_MODE, {30'h0, r, p}, BCFG_RESP_OKAY);
		for (int i = 2; i < 8; i++)
			wr(8'(i * 4), 32'hFFFF_FFFF, 4'hF, BCFG_RESP_OKAY);
		rd(8'h08, 32'h0604_0000, BCFG_RESP_OKAY);
		rd(8'h0C, {16'h0001, r ? 8'hFF : pl, 8'h3C}, BCFG_RESP_OKAY);
		rd(8'h18, {r ? sl : 8'hFF, 24'hFF_FFFF}, BCFG_RESP_OKAY);
		rd(8'h1C, 32'h0000_F1F1, BCFG_RESP_OKAY);
		rd(8'h14, 32'h0000_0000, BCFG_RESP_OKAY);
		wr(8'h18, 32'h0000_0000, 4'h2, BCFG_RESP_OKAY);
		`CHK("sec_bus", 8'h00, cfg_sec_bus)
		`CHK("pri_bus", 8'hFF, cfg_pri_bus)
		`CHK("sub_bus", 8'hFF, cfg_sub_bus)
		`CHK("cache", 4'hF, cfg_cache_line)
		`CHK("io_base", 4'hF, cfg_io_base)
		`CHK("io_limit", 4'hF, cfg_io_limit)
		$display("mode test %0d%0d done", r, p);
	endtask : t_mode
	task automatic t_err();
		wr(8'h24, 32'h0000_0000, 4'hF, BCFG_RESP_SLVERR);
		rd(8'h24, 32'h0000_0000, BCFG_RESP_SLVERR);
		rd(8'h1C, 32'h0000_F1F1, BCFG_RESP_OKAY);
		wr(BCFG_OFF_MODE, 32'h0000_0000, 4'hF, BCFG_RESP_OKAY);
		rd(BCFG_OFF_MODE, 32'h0000_0003, BCFG_RESP_OKAY);
		$display("error test done");
	endtask : t_err
	// Holds bready and rready low so the answers must stand
	task automatic t_stall();
		stall = 3;
		wr(BCFG_OFF_BUS, 32'h0000_5A00, 4'h2, BCFG_RESP_OKAY);
		rd(BCFG_OFF_BUS, 32'h00FF_5AFF, BCFG_RESP_OKAY);
		stall = 0;
		`CHK("sec_bus", 8'h5A, cfg_sec_bus)
		$display("stall test done");
	endtask : t_stall
	task automatic conclude();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : conclude
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		aclk = 0;
		forever #2.5 aclk = ~aclk;
	end
	initial
	begin
		{aresetn, mode_reverse, mode_pcix, s_axi_awvalid} = '0;
		{s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		{s_axi_awprot, s_axi_arprot} = '0;
		for (int m = 0; m < 4; m++)
			t_mode(m[1], m[0]);
		t_err();
		t_stall();
		conclude();
	end
	initial
	begin
		#20000;
		num_errors++;
		conclude();
	end
endmodule : tb
bind bcfg_top bcfg_checker chk (.*);
`default_nettype wire
